/* rtl/esp_core.sv */
// Enhanced serial port: transmit queue and four-mode serial engine
// Notes on behaviour
// - Two mode bits pick synchronous, 10-bit timer, 11-bit fixed, 11-bit timer.
// - Buffer writes feed the transmitter; reads return a separate receive buffer.
// - Synchronous mode is half duplex; asynchronous modes send and receive together.
// - Synchronous: eight bits LSB first on data pin, shift clock out, osc/12.
// - Synchronous send: gate set lead 1 low 2; clear lead 3 low 6.
// - Synchronous send sets transmit done after the eighth bit.
// - Synchronous receive when allowed and done clear; done after eighth rise.
// - 10-bit frame: start 0, eight data LSB first, stop 1 to ninth field.
// - 10-bit mode bit rate is timer overflow over 16 or 32.
// - Sending aligns to bit rollovers; done set at the tenth rollover.
// - Asynchronous receiver only runs while receive allow is high.
// - Receiver hunts falling edge at 16x and resets its divider there.
// - Each bit is the majority of samples in states seven to nine.
// - A start bit voted 1 abandons the frame and resumes the hunt.
// - 10-bit frame stored only if done clear and gate clear or stop 1.
// - Receiver resumes the hunt at the middle of the stop bit.
// - 11-bit frame adds the ninth bit from the transmit ninth field.
// - Fixed 11-bit mode runs at osc over 32 or 64.
// - Fixed 11-bit mode sends on rollovers; done at the eleventh.
// - 11-bit frame stored only if done clear and gate clear or ninth 1.
// - Timer 11-bit mode equals fixed mode but takes the timer rate.
// - Timer 2 baud use: 16-bit reload counter, no overflow flag, edge flag.
// - Missing stop bit sets the frame error flag until software clears it.
// - Control bit 7 shows frame error or mode bit, by the select bit.
`timescale 1ns/1ps

// Transmit queue with valid and ready on both sides
module esp_fifo
#(
	parameter int WIDTH = 9,
	parameter int DEPTH = 16
)
(
	input  wire logic             ref_clk,   // System clock
	input  wire logic             rst,       // Asynchronous reset
	input  wire logic             in_valid,  // Word offered
	output logic                  in_ready,  // Room for a word
	input  wire logic [WIDTH-1:0] in_data,   // Offered word
	output logic                  out_valid, // Word waiting
	input  wire logic             out_ready, // Word taken
	output logic      [WIDTH-1:0] out_data   // Oldest word
);
	localparam int PW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [PW-1:0]    wr_ptr;
	logic [PW-1:0]    rd_ptr;
	logic [PW:0]      count;
	logic             push;
	logic             pop;

	// Honest full and empty from the fill count
	assign in_ready  = (count != (PW+1)'(DEPTH));
	assign out_valid = (count != '0);
	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;
	assign out_data  = mem[rd_ptr];

	// Storage array
	always_ff @(posedge ref_clk)
	begin
		if (push)
			mem[wr_ptr] <= in_data;
	end

	// Pointers wrap over the depth
	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count  <= '0;
		end
		else
		begin
			if (push)
				wr_ptr <= (wr_ptr == PW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
			if (pop)
				rd_ptr <= (rd_ptr == PW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
			count <= count + (PW+1)'(push) - (PW+1)'(pop);
		end
	end
endmodule

// Serial port top
module esp_core
#(
	parameter int DEPTH = esp_pkg::FIFO_DEPTH
)
(
	input  wire logic       ref_clk,                // 100 MHz clock
	input  wire logic       rst,                    // Async reset
	input  wire logic       mode_select_bit_a,      // Mode bit, low
	input  wire logic       mode_select_bit_b,      // Mode bit, high
	input  wire logic       multiproc_gate,         // Multiproc gate
	input  wire logic       rx_enable,              // Receive allow
	input  wire logic       tx_ninth_bit,           // Ninth bit to send
	input  wire logic       baud_doubler,           // Rate doubling
	input  wire logic       frame_flag_select,      // Bit 7 select
	input  wire logic       tx_baud_from_t2,        // Tx rate from t2
	input  wire logic       rx_baud_from_t2,        // Rx rate from t2
	input  wire logic       timer1_overflow,        // Timer 1 pulse
	input  wire logic [15:0] timer2_reload,         // Timer 2 reload
	input  wire logic       timer2_external_enable, // Ext pin enable
	input  wire logic       timer2_external_pin,    // Ext pin level
	input  wire logic       timer2_external_clear,  // Clear ext flag
	input  wire logic       buf_wr_valid,           // Buffer write
	input  wire logic [7:0] buf_wr_data,            // Written byte
	output logic            buf_wr_ready,           // Queue has room
	output logic      [7:0] serial_buffer,          // Receive buffer
	output logic            rx_ninth_bit,           // Received ninth
	output logic            transmit_done_flag,     // Send done
	input  wire logic       tx_done_clear,          // Clear send done
	output logic            receive_done_flag,      // Receive done
	input  wire logic       rx_done_clear,          // Clear rx done
	output logic            frame_error_flag,       // Frame error
	input  wire logic       frame_error_clear,      // Clear error
	output logic            serial_control_bit7,    // Shared bit 7
	output logic            timer2_overflow_flag,   // Stays low
	output logic            timer2_external_flag,   // Ext edge seen
	input  wire logic       rxd_in,                 // Data pin level
	output logic            rxd_out,                // Data pin drive
	output logic            rxd_oe_n,               // Low drives pin
	output logic            txd                     // Line or clock
);
	esp_pkg::esp_mode_type  mode;
	esp_pkg::esp_sync_type  sync_state;
	esp_pkg::esp_rx_type    rx_state;
	esp_pkg::esp_frame_type wr_frame;
	esp_pkg::esp_frame_type tx_frame;
	logic                   mode0;
	logic                   long_frame;
	logic                   fixed_rate;
	logic [3:0]             frame_last;
	logic                   tx_valid;
	logic                   tx_pop;
	logic [esp_pkg::T2_W-1:0] t2_count;
	logic                   t2_run;
	logic                   t2_ovf;
	logic                   timer2_external_pin_last;
	logic [1:0]             os_tick;
	logic [1:0]             rate_sel_t2;

	// Mode decode
	assign mode = esp_pkg::esp_mode_type'({mode_select_bit_b,
		mode_select_bit_a});
	assign mode0      = (mode == esp_pkg::ESP_MODE_SYNC);
	assign fixed_rate = (mode == esp_pkg::ESP_MODE_FIXED11);
	assign long_frame = (mode == esp_pkg::ESP_MODE_FIXED11) ||
		(mode == esp_pkg::ESP_MODE_TIMER11);
	assign frame_last = long_frame ? esp_pkg::LONG_LAST :
		esp_pkg::SHORT_LAST;

	// Shared bit 7 view of the frame error flag and the low mode bit
	assign serial_control_bit7 = frame_flag_select ? frame_error_flag :
		mode_select_bit_a;

	// Timer 2 as auto-reload baud counter; overflow flag never set
	assign t2_run = tx_baud_from_t2 || rx_baud_from_t2;
	assign t2_ovf = t2_run && (t2_count == '1);
	assign timer2_overflow_flag = 1'b0;
	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
			t2_count <= '0;
		else if (t2_run)
			t2_count <= t2_ovf ? timer2_reload : t2_count + 1'b1;
	end

	// External pin falling edge flag, set wins over clear
	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			timer2_external_pin_last            <= 1'b1;
			timer2_external_flag <= 1'b0;
		end
		else
		begin
			timer2_external_pin_last <= timer2_external_pin;
			if (timer2_external_pin_last && !timer2_external_pin && timer2_external_enable)
				timer2_external_flag <= 1'b1;
			else if (timer2_external_clear)
				timer2_external_flag <= 1'b0;
		end
	end

	// Per direction prescaler to the 16x tick: 0 is transmit, 1 receive
	assign rate_sel_t2 = {rx_baud_from_t2, tx_baud_from_t2};
	for (genvar i = 0; i < 2; i++)
	begin : g_rate
		logic [1:0] pre;
		logic [1:0] term;
		logic       src;
		assign src  = fixed_rate ? 1'b1 :
			(rate_sel_t2[i] ? t2_ovf : timer1_overflow);
		assign term = fixed_rate ?
			(baud_doubler ? esp_pkg::PRE_FIXED_FAST :
				esp_pkg::PRE_FIXED_SLOW) :
			(baud_doubler ? esp_pkg::PRE_TIMER_FAST :
				esp_pkg::PRE_TIMER_SLOW);
		assign os_tick[i] = src && (pre == term);
		always_ff @(posedge ref_clk or posedge rst)
		begin
			if (rst)
				pre <= '0;
			else if (src)
				pre <= (pre == term) ? '0 : pre + 1'b1;
		end
	end

	// Transmit queue between buffer writes and the shifters
	assign wr_frame = '{ninth: tx_ninth_bit, data: buf_wr_data};
	esp_fifo #(.WIDTH(esp_pkg::FRAME_W), .DEPTH(DEPTH)) u_fifo
	(
		.ref_clk   (ref_clk),
		.rst       (rst),
		.in_valid  (buf_wr_valid),
		.in_ready  (buf_wr_ready),
		.in_data   (wr_frame),
		.out_valid (tx_valid),
		.out_ready (tx_pop),
		.out_data  (tx_frame)
	);

	// ---- Synchronous shift engine
	logic [3:0] sync_phase;
	logic [2:0] sync_count;
	logic [7:0] sync_sh;
	logic [3:0] sync_lead;
	logic [3:0] sync_rise;
	logic       sync_cell_end;
	logic       sync_rise_pt;
	logic       sync_tx_done;
	logic       sync_rx_done;
	logic       sclk_low;
	logic       atx_busy;

	assign tx_pop = tx_valid && (mode0 ?
		(sync_state == esp_pkg::ESP_SYNC_IDLE) : !atx_busy);
	assign sync_lead = multiproc_gate ? esp_pkg::SYNC_LEAD_FAST :
		esp_pkg::SYNC_LEAD_SLOW;
	assign sync_rise = multiproc_gate ? esp_pkg::SYNC_RISE_FAST :
		esp_pkg::SYNC_RISE_SLOW;
	assign sync_cell_end = (sync_phase == esp_pkg::SYNC_CELL_LAST);
	assign sync_rise_pt  = (sync_phase == sync_rise);
	assign sync_tx_done  = (sync_state == esp_pkg::ESP_SYNC_TX) &&
		sync_cell_end && (sync_count == esp_pkg::SYNC_LAST_BIT);
	assign sync_rx_done  = (sync_state == esp_pkg::ESP_SYNC_RX) &&
		sync_rise_pt && (sync_count == esp_pkg::SYNC_LAST_BIT);
	assign sclk_low = (sync_state != esp_pkg::ESP_SYNC_IDLE) &&
		(sync_phase >= sync_lead) && (sync_phase < sync_rise);

	// Half duplex: one engine either sends or receives
	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			sync_state <= esp_pkg::ESP_SYNC_IDLE;
			sync_phase <= '0;
			sync_count <= '0;
			sync_sh    <= '0;
		end
		else if (!mode0)
			sync_state <= esp_pkg::ESP_SYNC_IDLE;
		else
		begin
			unique case (sync_state)
				esp_pkg::ESP_SYNC_IDLE:
				begin
					sync_phase <= '0;
					sync_count <= '0;
					if (tx_pop)
					begin
						sync_state <= esp_pkg::ESP_SYNC_TX;
						sync_sh    <= tx_frame.data;
					end
					else if (rx_enable && !receive_done_flag)
						sync_state <= esp_pkg::ESP_SYNC_RX;
				end
				esp_pkg::ESP_SYNC_TX, esp_pkg::ESP_SYNC_RX:
				begin
					sync_phase <= sync_cell_end ? '0 : sync_phase + 1'b1;
					if (sync_cell_end)
						sync_count <= sync_count + 1'b1;
					if (sync_state == esp_pkg::ESP_SYNC_TX && sync_cell_end)
						sync_sh <= {1'b0, sync_sh[7:1]};
					if (sync_state == esp_pkg::ESP_SYNC_RX && sync_rise_pt)
						sync_sh <= {rxd_in, sync_sh[7:1]};
					if (sync_tx_done || sync_rx_done)
						sync_state <= esp_pkg::ESP_SYNC_IDLE;
				end
			endcase
		end
	end

	// ---- Asynchronous transmitter on free running rollovers
	logic [3:0]  atx_phase;
	logic [3:0]  atx_count;
	logic [10:0] atx_sh;
	logic        atx_line;
	logic        atx_roll;
	logic        atx_done;

	assign atx_roll = os_tick[0] && (atx_phase == esp_pkg::PHASE_LAST);
	assign atx_done = atx_busy && atx_roll &&
		(atx_count == frame_last);
	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			atx_phase <= '0;
			atx_count <= '0;
			atx_sh    <= '1;
			atx_line  <= 1'b1;
			atx_busy  <= 1'b0;
		end
		else
		begin
			if (os_tick[0])
				atx_phase <= atx_phase + 1'b1;
			if (mode0)
			begin
				atx_busy <= 1'b0;
				atx_line <= 1'b1;
			end
			else if (tx_pop)
			begin
				atx_busy  <= 1'b1;
				atx_count <= '0;
				atx_sh    <= {1'b1, long_frame ? tx_frame.ninth : 1'b1,
					tx_frame.data, 1'b0};
			end
			else if (atx_busy && atx_roll)
			begin
				atx_line  <= atx_sh[0];
				atx_sh    <= {1'b1, atx_sh[10:1]};
				atx_count <= atx_count + 1'b1;
				if (atx_done)
					atx_busy <= 1'b0;
			end
		end
	end

	// ---- Asynchronous receiver
	logic       rx_on;
	logic       rx_tick;
	logic [3:0] rx_phase;
	logic [3:0] rx_idx;
	logic [7:0] rx_sh;
	logic       rx_s7;
	logic       rx_s8;
	logic       rx_last;
	logic       rx_ninth_cap;
	logic       start_edge;
	logic       vote_pt;
	logic       vote;
	logic       stop_pt;
	logic       rx_store;

	assign rx_on      = rx_enable && !mode0;
	assign rx_tick    = os_tick[1];
	assign start_edge = rx_on && (rx_state == esp_pkg::ESP_RX_IDLE) &&
		rx_tick && rx_last && !rxd_in;
	assign vote_pt = (rx_state == esp_pkg::ESP_RX_BUSY) && rx_tick &&
		(rx_phase == esp_pkg::VOTE_C);
	assign vote = (rx_s7 && rx_s8) || (rx_s7 && rxd_in) ||
		(rx_s8 && rxd_in);
	assign stop_pt  = vote_pt && (rx_idx == frame_last);
	assign rx_store = stop_pt && !receive_done_flag && (!multiproc_gate ||
		(long_frame ? rx_ninth_cap : vote));

	// Frame sequencing, divider restart on the start edge
	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			rx_state <= esp_pkg::ESP_RX_IDLE;
			rx_phase <= '0;
			rx_idx   <= '0;
			rx_last  <= 1'b1;
		end
		else
		begin
			if (rx_tick)
				rx_last <= rxd_in;
			if (!rx_on)
				rx_state <= esp_pkg::ESP_RX_IDLE;
			else if (start_edge)
			begin
				rx_state <= esp_pkg::ESP_RX_BUSY;
				rx_phase <= '0;
				rx_idx   <= '0;
			end
			else if (rx_state == esp_pkg::ESP_RX_BUSY && rx_tick)
			begin
				rx_phase <= rx_phase + 1'b1;
				if (vote_pt)
					rx_idx <= rx_idx + 1'b1;
				if (vote_pt && rx_idx == '0 && vote)
					rx_state <= esp_pkg::ESP_RX_IDLE;
				if (stop_pt)
					rx_state <= esp_pkg::ESP_RX_IDLE;
			end
		end
	end

	// Samples for voting and the data shifter
	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			rx_s7        <= 1'b1;
			rx_s8        <= 1'b1;
			rx_sh        <= '0;
			rx_ninth_cap <= 1'b0;
		end
		else if (rx_state == esp_pkg::ESP_RX_BUSY && rx_tick)
		begin
			if (rx_phase == esp_pkg::VOTE_A)
				rx_s7 <= rxd_in;
			if (rx_phase == esp_pkg::VOTE_B)
				rx_s8 <= rxd_in;
			if (vote_pt && rx_idx >= esp_pkg::DATA_FIRST &&
				rx_idx <= esp_pkg::DATA_LAST)
				rx_sh <= {vote, rx_sh[7:1]};
			if (vote_pt && long_frame && rx_idx == esp_pkg::NINTH_IDX)
				rx_ninth_cap <= vote;
		end
	end

	// Receive buffer and ninth bit field
	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			serial_buffer <= '0;
			rx_ninth_bit  <= 1'b0;
		end
		else if (sync_rx_done)
			serial_buffer <= {rxd_in, sync_sh[7:1]};
		else if (rx_store)
		begin
			serial_buffer <= rx_sh;
			rx_ninth_bit  <= long_frame ? rx_ninth_cap : vote;
		end
	end

	// Done and error flags, hardware set wins over clear
	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			transmit_done_flag <= 1'b0;
			receive_done_flag  <= 1'b0;
			frame_error_flag   <= 1'b0;
		end
		else
		begin
			if (sync_tx_done || atx_done)
				transmit_done_flag <= 1'b1;
			else if (tx_done_clear)
				transmit_done_flag <= 1'b0;
			if (sync_rx_done || rx_store)
				receive_done_flag <= 1'b1;
			else if (rx_done_clear)
				receive_done_flag <= 1'b0;
			if (stop_pt && !vote)
				frame_error_flag <= 1'b1;
			else if (frame_error_clear)
				frame_error_flag <= 1'b0;
		end
	end

	// Pin drivers from flip-flops
	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			txd      <= 1'b1;
			rxd_out  <= 1'b1;
			rxd_oe_n <= 1'b1;
		end
		else
		begin
			txd <= mode0 ? !sclk_low : atx_line;
			rxd_out  <= (sync_state == esp_pkg::ESP_SYNC_TX) ? sync_sh[0] : 1'b1;
			rxd_oe_n <= (sync_state != esp_pkg::ESP_SYNC_TX);
		end
	end

	// Checks
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);

	sequence s_low_fast;
		!txd ##1 txd;
	endsequence
	sequence s_low_slow;
		!txd [*5] ##1 txd;
	endsequence

	a_sclk_fast: assert property ($fell(txd) && mode0 && multiproc_gate &&
		$past(multiproc_gate) |-> ##1 s_low_fast)
		else $error("shift clock low time wrong with gate set");
	a_sclk_slow: assert property ($fell(txd) && mode0 && !multiproc_gate &&
		$past(!multiproc_gate) && $stable(mode) |-> ##1 s_low_slow)
		else $error("shift clock low time wrong with gate clear");
	a_sync_tidone: assert property (sync_tx_done |=> transmit_done_flag)
		else $error("send done missing after eighth bit");
	a_async_end: assert property (atx_done |=> transmit_done_flag &&
		!atx_busy && $past(atx_count) == frame_last)
		else $error("async send ended at wrong rollover");
	a_edge_align: assert property (start_edge |=> rx_phase == '0 &&
		rx_state == esp_pkg::ESP_RX_BUSY)
		else $error("divider not restarted on start edge");
	a_start_abort: assert property (vote_pt && rx_idx == '0 && vote
		|=> rx_state == esp_pkg::ESP_RX_IDLE)
		else $error("bad start bit not abandoned");
	a_store_gate: assert property (rx_store |-> !receive_done_flag ##1
		receive_done_flag && serial_buffer == $past(rx_sh))
		else $error("frame stored against gate");
	a_rx_allow: assert property (!rx_enable |=> rx_state ==
		esp_pkg::ESP_RX_IDLE)
		else $error("receiver runs while disallowed");
	a_fe_sticky: assert property (frame_error_flag && !frame_error_clear
		|=> frame_error_flag)
		else $error("frame error cleared by hardware");
	a_t2_reload: assert property (t2_ovf |=>
		t2_count == $past(timer2_reload))
		else $error("timer 2 did not reload");
endmodule

/* rtl/esp_pkg.sv */
// Shared constants and types of the enhanced serial port
package esp_pkg;
	// Serial operating modes, index {mode_select_bit_b, mode_select_bit_a}
	typedef enum logic [1:0]
	{
		ESP_MODE_SYNC    = 2'b00,
		ESP_MODE_ASYNC10 = 2'b01,
		ESP_MODE_FIXED11 = 2'b10,
		ESP_MODE_TIMER11 = 2'b11
	} esp_mode_type;

	// Shift engine of the synchronous mode
	typedef enum logic [1:0]
	{
		ESP_SYNC_IDLE = 2'b00,
		ESP_SYNC_TX   = 2'b01,
		ESP_SYNC_RX   = 2'b10
	} esp_sync_type;

	// Asynchronous receiver
	typedef enum logic
	{
		ESP_RX_IDLE = 1'b0,
		ESP_RX_BUSY = 1'b1
	} esp_rx_type;

	// One queued transmit word
	typedef struct packed
	{
		logic       ninth;
		logic [7:0] data;
	} esp_frame_type;

	localparam int FRAME_W   = 9;
	localparam int FIFO_DEPTH = 16;
	localparam int T2_W      = 16;

	// Synchronous shift cell, counted in oscillator periods
	localparam logic [3:0] SYNC_CELL_LAST = 4'hb;
	localparam logic [3:0] SYNC_LEAD_FAST = 4'h1;
	localparam logic [3:0] SYNC_RISE_FAST = 4'h3;
	localparam logic [3:0] SYNC_LEAD_SLOW = 4'h3;
	localparam logic [3:0] SYNC_RISE_SLOW = 4'h9;
	localparam logic [2:0] SYNC_LAST_BIT  = 3'h7;

	// Oversampling phases and voting states
	localparam logic [3:0] PHASE_LAST = 4'hf;
	localparam logic [3:0] VOTE_A     = 4'h7;
	localparam logic [3:0] VOTE_B     = 4'h8;
	localparam logic [3:0] VOTE_C     = 4'h9;

	// Index of the stop bit and of the ninth bit in a frame
	localparam logic [3:0] SHORT_LAST = 4'h9;
	localparam logic [3:0] LONG_LAST  = 4'ha;
	localparam logic [3:0] NINTH_IDX  = 4'h9;
	localparam logic [3:0] DATA_FIRST = 4'h1;
	localparam logic [3:0] DATA_LAST  = 4'h8;

	// Prescaler terminal counts ahead of the 16x tick
	localparam logic [1:0] PRE_FIXED_FAST = 2'h1;
	localparam logic [1:0] PRE_FIXED_SLOW = 2'h3;
	localparam logic [1:0] PRE_TIMER_FAST = 2'h0;
	localparam logic [1:0] PRE_TIMER_SLOW = 2'h1;
endpackage

/* testbench/enhanced_serial_port_tb.sv */
// Self-checking bench of the enhanced serial port
`timescale 1ns/1ps

module enhanced_serial_port_tb;
	logic        ref_clk, rst, mode_select_bit_a, mode_select_bit_b;
	logic        multiproc_gate, rx_enable, tx_ninth_bit, baud_doubler;
	logic        frame_flag_select, tx_baud_from_t2, rx_baud_from_t2;
	logic        timer1_overflow, timer2_external_enable, buf_wr_valid;
	logic        timer2_external_pin, timer2_external_clear, tx_done_clear;
	logic        rx_done_clear, frame_error_clear, buf_wr_ready, txd;
	logic        rx_ninth_bit, transmit_done_flag, receive_done_flag;
	logic        frame_error_flag, serial_control_bit7, rxd_oe_n, far_line;
	logic        timer2_overflow_flag, timer2_external_flag, rxd_out;
	logic [15:0] timer2_reload;
	logic [7:0]  buf_wr_data, serial_buffer, got8;
	logic [10:0] got;
	wire         rxd_in = rxd_oe_n ? far_line : rxd_out; // Shared pin
	int          errors, n_tests, lo, n;

	// Free-running 100 MHz clock
	initial
	begin
		ref_clk = 1'b0;
		forever #5 ref_clk = ~ref_clk;
	end

	esp_core esp_core_inst (.*);
	esp_far_end esp_far_end_inst
		(.ref_clk, .txd, .pin(rxd_in), .line(far_line));

	task automatic step(input int k = 1);
		repeat (k) @(posedge ref_clk);
		#1;
	endtask

	task automatic chk(input string s, input logic [10:0] e, input logic [10:0] v);
		n_tests++;
		if (v !== e)
		begin
			errors++;
			$display("MISMATCH %s expected %h seen %h", s, e, v);
		end
	endtask

	task automatic give_verdict();
		$display("checks %0d mismatches %0d", n_tests, errors);
		if (errors == 0 && n_tests > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	// Bounded wait on a done flag; running out ends the run
	task automatic wait_flag(input logic rx);
		int t;
		t = 0;
		while ((rx ? receive_done_flag : transmit_done_flag) !== 1'b1)
		begin
			step();
			t++;
			if (t == 5000)
			begin
				errors++;
				give_verdict();
			end
		end
	endtask

	task automatic wr(input logic [7:0] d, input logic ninth);
		{buf_wr_data, tx_ninth_bit, buf_wr_valid} = {d, ninth, 1'b1};
		step();
		buf_wr_valid = 1'b0;
	endtask

	// Clear pulses for send done, receive done, frame error
	task automatic clr(input logic [2:0] c);
		{tx_done_clear, rx_done_clear, frame_error_clear} = c;
		step();
		{tx_done_clear, rx_done_clear, frame_error_clear} = 3'h0;
	endtask

	// One frame at 32 clocks a bit into the port, then status and buffer
	task automatic rx_case(input logic g, input logic [2:0] c,
		input logic [7:0] d, input logic [1:0] tail, input logic [10:0] e);
		clr(c);
		multiproc_gate = g;
		esp_far_end_inst.send({tail, d, 1'b0}, 11, 32);
		step(20);
		chk("rx status", e, {frame_error_flag, receive_done_flag,
			rx_ninth_bit, serial_buffer});
	endtask

	initial
	begin
		{rst, mode_select_bit_a, mode_select_bit_b, multiproc_gate} = 4'h8;
		{rx_enable, tx_ninth_bit, baud_doubler, frame_flag_select} = 4'h2;
		{tx_baud_from_t2, rx_baud_from_t2, timer1_overflow} = 3'h1;
		{timer2_external_enable, timer2_external_pin} = 2'h1;
		{timer2_external_clear, buf_wr_valid} = 2'h0;
		{tx_done_clear, rx_done_clear, frame_error_clear} = 3'h0;
		{timer2_reload, buf_wr_data} = 24'hffff00;
		errors = 0;
		n_tests = 0;
		step(12);
		rst = 1'b0;
		chk("reset pins", 11'h70, {txd, rxd_oe_n, buf_wr_ready,
			transmit_done_flag, receive_done_flag, frame_error_flag,
			timer2_external_flag});
		// Timer 2 starts counting now; external edge flag and clear
		{tx_baud_from_t2, timer2_external_enable} = 2'h3;
		timer2_external_pin = 1'b0;
		step(3);
		chk("t2 flags", 11'h1, {timer2_overflow_flag,
			timer2_external_flag});
		timer2_external_clear = 1'b1;
		step();
		timer2_external_clear = 1'b0;
		step();
		chk("t2 ext clear", 11'h0, timer2_external_flag);
		// Synchronous send with both clock shapes
		for (int g = 0; g < 2; g++)
		begin
			multiproc_gate = g[0];
			wr(8'h96 ^ g[7:0], 1'b0);
			// Measure the first low phase while the partner captures
			fork
				esp_far_end_inst.sync_cap(got8);
				begin
					for (lo = 0; lo < 99 && txd !== 1'b0; lo++)
						step();
					for (lo = 0; lo < 99 && txd === 1'b0; lo++)
						step();
				end
			join
			chk("sync low", g ? 11'h2 : 11'h6, lo[10:0]);
			wait_flag(1'b0);
			chk("sync byte", {3'h0, 8'h96 ^ g[7:0]},
				{3'h0, got8});
			clr(3'h4);
		end
		// Synchronous receive
		{multiproc_gate, rx_enable} = 2'h1;
		esp_far_end_inst.sync_drive(8'h3c);
		wait_flag(1'b1);
		rx_enable = 1'b0;
		chk("sync rx", 11'h03c, {3'h0, serial_buffer});
		clr(3'h2);
		// Fixed-rate 11-bit mode, 32 clocks a bit
		{mode_select_bit_b, mode_select_bit_a, rx_enable} = 3'h5;
		wr(8'h5a, 1'b1);
		esp_far_end_inst.recv(11, 32, got);
		chk("m2 frame", {2'h3, 8'h5a, 1'b0}, got);
		wait_flag(1'b0);
		chk("m2 done", 11'h1, {10'h0, transmit_done_flag});
		esp_far_end_inst.send(11'h0, 1, 4);
		step(400);
		chk("glitch", 11'h0, {10'h0, receive_done_flag});
		rx_case(0, 3'h4, 8'hc3, 2'h2, 11'h2c3);
		rx_case(1, 3'h2, 8'h81, 2'h2, 11'h0c3);
		rx_case(1, 3'h0, 8'h81, 2'h3, 11'h381);
		rx_case(0, 3'h0, 8'h7e, 2'h2, 11'h381);
		rx_case(0, 3'h2, 8'h11, 2'h0, 11'h611);
		rx_case(0, 3'h2, 8'h22, 2'h2, 11'h622);
		frame_flag_select = 1'b1;
		step();
		chk("bit7 fe", 11'h1, {10'h0, serial_control_bit7});
		frame_flag_select = 1'b0;
		step();
		chk("bit7 mode", 11'h0, {10'h0, serial_control_bit7});
		clr(3'h7);
		// Let timer 2 reach its first overflow, then timer modes
		step(66000);
		for (int m = 1; m < 4; m += 2)
		begin
			{mode_select_bit_b, mode_select_bit_a} = m[1:0];
			rx_baud_from_t2 = m[1];
			n = (m == 1) ? 10 : 11;
			step();
			fork
				begin
					wr(8'ha7, 1'b0);
					esp_far_end_inst.recv(n, 16, got);
				end
				esp_far_end_inst.send({2'h3, 8'h4d, 1'b0}, n, 16);
			join
			step(20);
			chk("tx frame", {1'b1, m == 1, 8'ha7, 1'b0},
				got);
			chk("rx frame", 11'h34d, {frame_error_flag, receive_done_flag,
				rx_ninth_bit, serial_buffer});
			clr(3'h7);
		end
		// Fill the queue until refused, then let it drain
		for (n = 0; n < 40 && buf_wr_ready === 1'b1; n++)
		begin
			wr(n[7:0], 1'b0);
			step();
		end
		chk("queue fill", 11'h11, n[10:0]);
		step(3200);
		chk("queue drain", 11'h3, {9'h0, buf_wr_ready,
			transmit_done_flag});
		give_verdict();
	end
endmodule

/* testbench/esp_far_end.sv */
// Far-side serial device: async frames and shift-register partner
`timescale 1ns/1ps

module esp_far_end
(
	input  wire logic ref_clk, // System clock
	input  wire logic txd,     // Port line or shift clock
	input  wire logic pin,     // Resolved data pin
	output logic      line     // Our drive, high when released
);
	// Idle line rests high
	initial line = 1'b1;

	// Bounded wait for a level on the port's transmit pin
	task automatic wait_txd(input logic v);
		for (int t = 0; t < 5000 && txd !== v; t++)
			@(posedge ref_clk);
	endtask

	// Send bits LSB first, each held a fixed count of clocks
	task automatic send(input logic [10:0] b, input int n, input int clks);
		for (int i = 0; i < n; i++)
		begin
			line = b[i];
			repeat (clks) @(posedge ref_clk);
			#1;
		end
		line = 1'b1;
	endtask

	// Sample each bit of a port frame at its middle
	task automatic recv(input int n, input int clks, output logic [10:0] b);
		b = 11'h7ff;
		wait_txd(1'b0);
		repeat (clks / 2) @(posedge ref_clk);
		for (int i = 0; i < n; i++)
		begin
			#1;
			b[i] = txd;
			repeat (clks) @(posedge ref_clk);
		end
	endtask

	// Shift register: take the pin after each rising shift clock
	task automatic sync_cap(output logic [7:0] d);
		for (int i = 0; i < 8; i++)
		begin
			wait_txd(1'b0);
			wait_txd(1'b1);
			d[i] = pin;
		end
	endtask

	// Shift register source: new data on each falling shift clock
	task automatic sync_drive(input logic [7:0] d);
		for (int i = 0; i < 8; i++)
		begin
			wait_txd(1'b0);
			#1;
			line = d[i];
			wait_txd(1'b1);
		end
		line = 1'b1;
	endtask
endmodule
